// ===== scc_defs.svh
// constants for the system control coprocessor register bank
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// transfer instruction fields
`define SCC_DIR_BIT 20
`define SCC_SEL_HI 19
`define SCC_SEL_LO 16
`define SCC_CPN_HI 11
`define SCC_CPN_LO 8
`define SCC_FN_HI 7
`define SCC_FN_LO 5
`define SCC_MARK_BIT 4
`define SCC_SEC_HI 3
`define SCC_SEC_LO 0

// coprocessor number of this bank
`define SCC_CP_NUM 4'hF

// register selectors
`define SCC_REG_ID 4'h0
`define SCC_REG_CTRL 4'h1
`define SCC_REG_TTB 4'h2
`define SCC_REG_DOM 4'h3
`define SCC_REG_FSR 4'h5
`define SCC_REG_FAR 4'h6
`define SCC_REG_CACHE 4'h7
`define SCC_REG_TLB 4'h8
`define SCC_REG_TCI 4'hF

// control register bit positions
`define SCC_CTRL_MMU 0
`define SCC_CTRL_ALIGN 1
`define SCC_CTRL_DCACHE 2
`define SCC_CTRL_WBUF 3
`define SCC_CTRL_BIGEND 7
`define SCC_CTRL_SYS 8
`define SCC_CTRL_ROM 9
`define SCC_CTRL_ICACHE 12

// storage masks and reset values
`define SCC_CTRL_WMASK 32'h0000_138F
`define SCC_TTB_MASK 32'hFFFF_C000
`define SCC_FSR_MASK 32'h0000_00FF
`define SCC_ZERO32 32'h0000_0000

// result delay in core cycles
`define SCC_STALL_WR 2'h2
`define SCC_STALL_RD 2'h1
`define SCC_STALL_NONE 2'h0

`endif

// ===== scc_pkg.sv
// types shared by the system control coprocessor register bank
package scc_pkg;

  typedef logic [3:0] scc_sel_t;
  typedef logic [31:0] scc_word_t;

  // transfer direction as carried in the direction bit
  typedef enum logic {
    SCC_DIR_WRITE = 1'b0,
    SCC_DIR_READ = 1'b1
  } scc_dir_t;

endpackage : scc_pkg

// ===== scc_regs.sv
// system control coprocessor register bank with transfer decode
//
// Summary of operation
// - user-mode transfers refused, undefined trap raised
// - direction bit 1 reads, 0 writes
// - registers 7, 8, 15 are write-triggered operations
// - register 0 returns fixed ID with revision
// - control writable bits cleared on reset
// - control bits 13-31 ignore writes
// - control bit 0 enables memory management unit
// - control bit 1 enables alignment checking
// - control bit 2 enables data cache
// - control bit 3 enables write buffer
// - control bit 7 selects big endian
// - control bits 8, 9 feed access checks
// - control bit 12 enables instruction cache
// - page table base, low 14 bits ignored
// - domain register holds sixteen domain permissions
// - one issue cycle; stall 2 write, 1 read
`timescale 1ns/1ps
`include "scc_defs.svh"

module scc_regs #(
  parameter logic [27:0] ID_UPPER = 28'h5A5A_5A5, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic xfer_valid, // register transfer issued
  input wire logic [31:0] xfer_instr, // transfer instruction word
  input wire logic [31:0] xfer_wdata, // core register value for writes
  input wire logic user_mode, // core in unprivileged mode
  input wire logic fault_wr, // data fault capture strobe
  input wire logic [7:0] fault_status, // status of captured fault
  input wire logic [31:0] fault_addr, // address of captured fault
  output logic [31:0] rdata_r, // read result
  output logic rvalid_r, // read result valid pulse
  output logic undef_r, // undefined instruction trap pulse
  output logic stall_r, // result delay stall
  output logic [31:0] ctrl_r, // control register
  output logic [31:0] ttb_r, // page table base
  output logic [31:0] dom_r, // domain permissions
  output logic cache_op_r, // cache maintenance pulse
  output logic tlb_op_r, // translation buffer maintenance pulse
  output logic tci_op_r, // test, clock and idle pulse
  output logic [3:0] op_sel_r, // secondary selector of operation
  output logic [2:0] op_fn_r, // function field of operation
  output logic [31:0] op_data_r // data of operation
);

  scc_pkg::scc_sel_t sel;
  scc_pkg::scc_sel_t sec;
  scc_pkg::scc_dir_t dir;
  logic [2:0] fn;
  logic cp_hit;
  logic acc;
  logic acc_rd;
  logic acc_wr;
  logic [7:0] fsr_r;
  logic [31:0] far_r;
  logic [1:0] stall_cnt_r;
  logic [1:0] stall_cnt_nxt;
  logic [31:0] rdata_nxt;

  // selector match for an accepted write
  function automatic logic wr_to(input logic a, input scc_pkg::scc_sel_t s,
                                 input scc_pkg::scc_sel_t idx);
    wr_to = a && (s == idx);
  endfunction : wr_to

  // field extraction
  assign sel = xfer_instr[`SCC_SEL_HI:`SCC_SEL_LO];
  assign sec = xfer_instr[`SCC_SEC_HI:`SCC_SEC_LO];
  assign fn = xfer_instr[`SCC_FN_HI:`SCC_FN_LO];
  assign dir = scc_pkg::scc_dir_t'(xfer_instr[`SCC_DIR_BIT]);
  assign cp_hit = (xfer_instr[`SCC_CPN_HI:`SCC_CPN_LO] == `SCC_CP_NUM) &&
                  xfer_instr[`SCC_MARK_BIT];
  assign acc = xfer_valid && cp_hit && !user_mode;
  assign acc_rd = acc && (dir == scc_pkg::SCC_DIR_READ);
  assign acc_wr = acc && (dir == scc_pkg::SCC_DIR_WRITE);

  // trap for user mode or a foreign coprocessor
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      undef_r <= 1'b0;
    end else begin
      undef_r <= xfer_valid && (user_mode || !cp_hit);
    end
  end

  // control register; unused and reserved bits never stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `SCC_ZERO32;
    end else if (wr_to(acc_wr, sel, `SCC_REG_CTRL)) begin
      ctrl_r <= xfer_wdata & `SCC_CTRL_WMASK;
    end
  end

  // page table base
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ttb_r <= `SCC_ZERO32;
    end else if (wr_to(acc_wr, sel, `SCC_REG_TTB)) begin
      ttb_r <= xfer_wdata & `SCC_TTB_MASK;
    end
  end

  // domain permissions, two bits per domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dom_r <= `SCC_ZERO32;
    end else if (wr_to(acc_wr, sel, `SCC_REG_DOM)) begin
      dom_r <= xfer_wdata;
    end
  end

  // fault status: hardware capture wins over software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fsr_r <= 8'h00;
    end else if (fault_wr) begin
      fsr_r <= fault_status;
    end else if (wr_to(acc_wr, sel, `SCC_REG_FSR)) begin
      fsr_r <= xfer_wdata[7:0];
    end
  end

  // fault address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      far_r <= `SCC_ZERO32;
    end else if (fault_wr) begin
      far_r <= fault_addr;
    end else if (wr_to(acc_wr, sel, `SCC_REG_FAR)) begin
      far_r <= xfer_wdata;
    end
  end

  // operation registers: one-cycle pulses with their fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cache_op_r <= 1'b0;
      tlb_op_r <= 1'b0;
      tci_op_r <= 1'b0;
    end else begin
      cache_op_r <= wr_to(acc_wr, sel, `SCC_REG_CACHE);
      tlb_op_r <= wr_to(acc_wr, sel, `SCC_REG_TLB);
      tci_op_r <= wr_to(acc_wr, sel, `SCC_REG_TCI);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_sel_r <= 4'h0;
      op_fn_r <= 3'h0;
      op_data_r <= `SCC_ZERO32;
    end else if (acc_wr) begin
      op_sel_r <= sec;
      op_fn_r <= fn;
      op_data_r <= xfer_wdata;
    end
  end

  // read mux; reserved and write-only registers read zero
  always_comb begin
    rdata_nxt = `SCC_ZERO32;
    unique case (sel)
      `SCC_REG_ID: rdata_nxt = {ID_UPPER, REVISION};
      `SCC_REG_CTRL: rdata_nxt = ctrl_r;
      `SCC_REG_TTB: rdata_nxt = ttb_r;
      `SCC_REG_DOM: rdata_nxt = dom_r;
      `SCC_REG_FSR: rdata_nxt = `SCC_FSR_MASK & {24'h00_0000, fsr_r};
      `SCC_REG_FAR: rdata_nxt = far_r;
      default: rdata_nxt = `SCC_ZERO32;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= `SCC_ZERO32;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= acc_rd;
      if (acc_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // result delay counter
  always_comb begin
    stall_cnt_nxt = `SCC_STALL_NONE;
    if (acc_wr) begin
      stall_cnt_nxt = `SCC_STALL_WR;
    end else if (acc_rd) begin
      stall_cnt_nxt = `SCC_STALL_RD;
    end else if (stall_cnt_r != `SCC_STALL_NONE) begin
      stall_cnt_nxt = stall_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall_cnt_r <= `SCC_STALL_NONE;
      stall_r <= 1'b0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
      stall_r <= (stall_cnt_nxt != `SCC_STALL_NONE);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_quiet;
    acc_wr ##1 !acc [*2];
  endsequence

  sequence s_rd_quiet;
    acc_rd ##1 !acc;
  endsequence

  user_trap_a: assert property (xfer_valid && user_mode |=> undef_r && !rvalid_r)
    else $error("user-mode transfer not trapped");

  read_answer_a: assert property (acc_rd |=> rvalid_r)
    else $error("read gave no result");

  write_no_answer_a: assert property (acc_wr |=> !rvalid_r)
    else $error("write produced a read result");

  foreign_cp_a: assert property (xfer_valid && !cp_hit |=> undef_r && !rvalid_r)
    else $error("foreign coprocessor not trapped");

  op_pulse_a: assert property (acc_wr && sel == `SCC_REG_CACHE |=>
                               cache_op_r && op_sel_r == $past(sec) && !tlb_op_r)
    else $error("cache operation not issued");

  op_read_zero_a: assert property (acc_rd && sel == `SCC_REG_TCI |=> rdata_r == `SCC_ZERO32)
    else $error("operation register read not zero");

  id_read_a: assert property (acc_rd && sel == `SCC_REG_ID |=>
                              rdata_r[3:0] == REVISION && rdata_r[31:4] == ID_UPPER)
    else $error("identification read wrong");

  ctrl_reset_a: assert property (@(posedge clk) disable iff (1'b0)
                                 !rst_n |=> ctrl_r == `SCC_ZERO32)
    else $error("control not cleared by reset");

  ctrl_mask_a: assert property ((ctrl_r & ~`SCC_CTRL_WMASK) == `SCC_ZERO32)
    else $error("control holds unwritable bits");

  ctrl_write_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
                                 ctrl_r[`SCC_CTRL_MMU] == $past(xfer_wdata[`SCC_CTRL_MMU]) &&
                                 ctrl_r[`SCC_CTRL_ICACHE] == $past(xfer_wdata[`SCC_CTRL_ICACHE]))
    else $error("control write not stored");

  ttb_low_a: assert property (acc_wr && sel == `SCC_REG_TTB |=>
                              ttb_r[13:0] == 14'h0000 && ttb_r[31:14] == $past(xfer_wdata[31:14]))
    else $error("page table base wrong");

  dom_write_a: assert property (acc_wr && sel == `SCC_REG_DOM |=> dom_r == $past(xfer_wdata))
    else $error("domain register not written");

  wr_stall_a: assert property (s_wr_quiet |-> stall_r ##1 !stall_r)
    else $error("write stall length wrong");

  wr_stall_start_a: assert property (acc_wr |=> stall_r)
    else $error("write stall missing");

  rd_stall_a: assert property (s_rd_quiet |-> stall_r ##1 !stall_r)
    else $error("read stall length wrong");

  read_no_store_a: assert property (acc_rd |=>
      $stable(ctrl_r) && $stable(ttb_r) && $stable(dom_r))
    else $error("read changed a register");

  rvalid_cause_a: assert property (rvalid_r |-> $past(acc_rd))
    else $error("read result without a read");

  rdata_hold_a: assert property (!acc_rd |=> $stable(rdata_r))
    else $error("read result changed without a read");

  user_no_store_a: assert property (xfer_valid && user_mode |=>
      $stable(ctrl_r) && $stable(ttb_r) && $stable(dom_r))
    else $error("user-mode transfer changed a register");

  foreign_no_store_a: assert property (xfer_valid && !cp_hit |=>
      $stable(ctrl_r) && $stable(ttb_r) && $stable(dom_r))
    else $error("foreign transfer changed a register");

  undef_cause_a: assert property (undef_r |-> $past(xfer_valid) && !$past(acc))
    else $error("trap without a refused transfer");

  tlb_pulse_a: assert property (acc_wr && sel == `SCC_REG_TLB |=>
      tlb_op_r && !cache_op_r && !tci_op_r)
    else $error("translation buffer operation not issued");

  tci_pulse_a: assert property (acc_wr && sel == `SCC_REG_TCI |=>
      tci_op_r && !cache_op_r && !tlb_op_r)
    else $error("test clock idle operation not issued");

  op_quiet_a: assert property (!acc_wr |=> !cache_op_r && !tlb_op_r && !tci_op_r)
    else $error("operation pulse without a write");

  id_no_write_a: assert property (acc_wr && sel == `SCC_REG_ID |=>
      $stable(ctrl_r) && $stable(ttb_r) && $stable(dom_r))
    else $error("identification write changed a register");

  align_bit_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
      ctrl_r[`SCC_CTRL_ALIGN] == $past(xfer_wdata[`SCC_CTRL_ALIGN]))
    else $error("alignment enable not stored");

  dcache_bit_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
      ctrl_r[`SCC_CTRL_DCACHE] == $past(xfer_wdata[`SCC_CTRL_DCACHE]))
    else $error("data cache enable not stored");

  wbuf_bit_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
      ctrl_r[`SCC_CTRL_WBUF] == $past(xfer_wdata[`SCC_CTRL_WBUF]))
    else $error("write buffer enable not stored");

  endian_bit_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
      ctrl_r[`SCC_CTRL_BIGEND] == $past(xfer_wdata[`SCC_CTRL_BIGEND]))
    else $error("byte order select not stored");

  access_bits_a: assert property (acc_wr && sel == `SCC_REG_CTRL |=>
      ctrl_r[`SCC_CTRL_ROM:`SCC_CTRL_SYS] == $past(xfer_wdata[`SCC_CTRL_ROM:`SCC_CTRL_SYS]))
    else $error("access check selects not stored");

  ctrl_read_a: assert property (acc_rd && sel == `SCC_REG_CTRL |=>
      rdata_r == $past(ctrl_r) && (rdata_r & ~`SCC_CTRL_WMASK) == `SCC_ZERO32)
    else $error("control read wrong");

  ttb_read_a: assert property (acc_rd && sel == `SCC_REG_TTB |=> rdata_r == $past(ttb_r))
    else $error("page table base read wrong");

  dom_read_a: assert property (acc_rd && sel == `SCC_REG_DOM |=> rdata_r == $past(dom_r))
    else $error("domain register read wrong");

  op_fields_a: assert property (acc_wr |=>
      op_fn_r == $past(fn) && op_sel_r == $past(sec) && op_data_r == $past(xfer_wdata))
    else $error("operation fields not captured");

endmodule : scc_regs

// ===== scc_core_model.sv
// core pipeline model issuing coprocessor register transfers
`timescale 1ns/1ps
module scc_core_model (
  input wire logic clk, // core clock
  output logic xfer_valid, // transfer strobe
  output logic [31:0] xfer_instr, // instruction word
  output logic [31:0] xfer_wdata, // write data
  output logic user_mode // unprivileged mode
);
  initial begin
    xfer_valid = 1'b0;
    xfer_instr = 32'h0000_0000;
    xfer_wdata = 32'h0000_0000;
    user_mode = 1'b0;
  end
  // one transfer per call, back to back allowed
  task automatic xfer(input logic rd, input logic [3:0] sel, input logic [3:0] cp,
    input logic [2:0] fn, input logic [3:0] sec, input logic mk, input logic um,
    input logic [31:0] wd);
    @(negedge clk);
    xfer_valid = 1'b1;
    user_mode = um;
    xfer_instr = {4'hE, 4'hE, 3'h0, rd, sel, 4'h0, cp, fn, mk, sec};
    xfer_wdata = wd;
  endtask : xfer
  // strobe drops; instruction and write data lines show the inverse of what they held
  task automatic idle();
    @(negedge clk);
    xfer_valid = 1'b0;
    xfer_instr = ~xfer_instr;
    xfer_wdata = ~xfer_wdata;
  endtask : idle
endmodule : scc_core_model

// ===== testbench.sv
// self-checking bench for the coprocessor register bank
`timescale 1ns/1ps
`include "scc_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  localparam logic [27:0] IDU = 28'h1234567; // arbitrary value
  localparam logic [3:0] REV = 4'h3; // arbitrary value
  logic clk, rst_n, fault_wr, xfer_valid, user_mode, rvalid_r, undef_r, stall_r;
  logic cache_op_r, tlb_op_r, tci_op_r;
  logic [7:0] fault_status;
  logic [3:0] op_sel_r;
  logic [2:0] op_fn_r;
  logic [31:0] fault_addr, xfer_instr, xfer_wdata, rdata_r, ctrl_r, ttb_r, dom_r;
  logic [31:0] op_data_r, wv, cexp;
  logic [3:0] sels [3] = '{4'h7, 4'h8, 4'hF};
  logic [32:0] expq [$];
  int errors = 0;
  int n_tests = 0;
  int seed = 29573;
  scc_regs #(.ID_UPPER(IDU), .REVISION(REV)) dut (.clk(clk), .rst_n(rst_n),
    .xfer_valid(xfer_valid), .xfer_instr(xfer_instr), .xfer_wdata(xfer_wdata),
    .user_mode(user_mode), .fault_wr(fault_wr), .fault_status(fault_status),
    .fault_addr(fault_addr), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .undef_r(undef_r),
    .stall_r(stall_r), .ctrl_r(ctrl_r), .ttb_r(ttb_r), .dom_r(dom_r),
    .cache_op_r(cache_op_r), .tlb_op_r(tlb_op_r), .tci_op_r(tci_op_r),
    .op_sel_r(op_sel_r), .op_fn_r(op_fn_r), .op_data_r(op_data_r));
  scc_core_model core (.clk(clk), .xfer_valid(xfer_valid), .xfer_instr(xfer_instr),
    .xfer_wdata(xfer_wdata), .user_mode(user_mode));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic rd(input logic [3:0] sel, input logic [31:0] e);
    expq.push_back({1'b0, e});
    core.xfer(1'b1, sel, 4'hF, 3'h0, 4'h0, 1'b1, 1'b0, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [3:0] sel, input logic [3:0] sec, input logic [31:0] d);
    core.xfer(1'b0, sel, 4'hF, 3'h5, sec, 1'b1, 1'b0, d);
  endtask : wr
  task automatic bad(input logic [3:0] cp, input logic mk, input logic um);
    expq.push_back({1'b1, 32'h0000_0000});
    core.xfer(1'b0, 4'h1, cp, 3'h0, 4'h0, mk, um, 32'hFFFF_FFFF);
  endtask : bad
  // results are matched against the oldest noted expectation
  always @(negedge clk) begin
    if (rvalid_r === 1'b1 || undef_r === 1'b1) begin
      if (expq.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK({undef_r, undef_r ? 32'h0000_0000 : rdata_r}, expq.pop_front())
    end
  end
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    fault_wr = 1'b0;
    fault_status = 8'h00;
    fault_addr = 32'h0000_0000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    `CHK(ctrl_r, 32'h0000_0000)
    rd(4'h0, {IDU, REV});
    rd(4'h1, 32'h0000_0000);
    wr(4'h0, 4'h0, 32'hFFFF_FFFF);
    rd(4'h0, {IDU, REV});
    core.idle();
    `CHK(stall_r, 1'b1)
    core.idle();
    `CHK(stall_r, 1'b0)
    $display("test id done");
    for (int i = 0; i < 16; i++) begin
      wv = (i < 13) ? (32'h0000_0001 << i) : $random(seed);
      cexp = wv & `SCC_CTRL_WMASK;
      wr(4'h1, 4'h0, wv);
      rd(4'h1, cexp);
    end
    core.idle();
    `CHK(ctrl_r, cexp)
    wr(4'h1, 4'h0, wv);
    core.idle();
    `CHK(stall_r, 1'b1)
    core.idle();
    `CHK(stall_r, 1'b1)
    core.idle();
    `CHK(stall_r, 1'b0)
    $display("test control done");
    wv = $random(seed);
    wr(4'h2, 4'h0, wv);
    rd(4'h2, wv & `SCC_TTB_MASK);
    wr(4'h3, 4'h0, ~wv);
    rd(4'h3, ~wv);
    core.idle();
    `CHK(ttb_r, wv & `SCC_TTB_MASK)
    `CHK(dom_r, ~wv)
    $display("test tables done");
    for (int i = 0; i < 3; i++) begin
      wv = $random(seed);
      wr(sels[i], 4'(i + 9), wv);
      core.idle();
      `CHK({cache_op_r, tlb_op_r, tci_op_r}, 3'b100 >> i)
      `CHK({op_sel_r, op_fn_r, op_data_r}, {4'(i + 9), 3'h5, wv})
      rd(sels[i], 32'h0000_0000);
    end
    $display("test operations done");
    bad(4'hF, 1'b1, 1'b1);
    bad(4'hE, 1'b1, 1'b0);
    bad(4'hF, 1'b0, 1'b0);
    rd(4'h1, cexp);
    $display("test refusals done");
    core.idle();
    wv = $random(seed);
    fault_wr = 1'b1;
    fault_status = wv[15:8];
    fault_addr = ~wv;
    @(negedge clk);
    fault_wr = 1'b0;
    rd(4'h5, {24'h00_0000, wv[15:8]});
    rd(4'h6, ~wv);
    core.idle();
    repeat (3) @(negedge clk);
    `CHK(expq.size(), 0)
    $display("test faults done");
    wr(4'h1, 4'h0, 32'hFFFF_FFFF);
    core.idle();
    `CHK(ctrl_r, `SCC_CTRL_WMASK)
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    `CHK(ctrl_r, 32'h0000_0000)
    `CHK(stall_r, 1'b0)
    rd(4'h1, 32'h0000_0000);
    core.idle();
    repeat (2) @(negedge clk);
    `CHK(expq.size(), 0)
    $display("test reset done");
    tally_and_finish();
  end
endmodule : testbench
